// *** inc/psp_pkg.sv ***
// Shared constants and types of the pipelined burst static memory port
package psp_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // Widths of the external bus
  localparam int ADDR_W      = 20;               // Word address pins
  localparam int DATA_W      = 32;               // Data pins, four byte lanes
  localparam int LANES       = 4;                // Byte lanes per word
  localparam int LANE_W      = 8;                // Bits per byte lane
  localparam int BURST_W     = 2;                // Low address bits stepped by a burst
  ////////////////////////////////////////////////////////////////////////////
  // Local storage and buffering
  localparam int IDX_W       = 4;                // Index bits of the flip-flop store
  localparam int MEM_DEPTH   = 16;               // Words held in flip-flops
  localparam int FIFO_DEPTH  = 8;                // Write buffer depth
  localparam int FIFO_W      = ADDR_W + LANES + DATA_W;
  localparam int SYNC_STAGES = 3;                // Flops on each of the sleep and order pins; output enable has none
  ////////////////////////////////////////////////////////////////////////////
  // Reset and step values
  localparam logic [BURST_W-1:0] CNT_ZERO  = 2'h0;
  localparam logic [BURST_W-1:0] CNT_ONE   = 2'h1;
  localparam logic [LANES-1:0]   LANES_ALL = 4'hf;
  localparam logic [LANES-1:0]   LANES_NONE = 4'h0;
  localparam logic [SYNC_STAGES-1:0] SYNC_LO = 3'h0;
  localparam logic [SYNC_STAGES-1:0] SYNC_HI = 3'h7;
  ////////////////////////////////////////////////////////////////////////////
  // Burst state, one-hot
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,                           // Deselected or asleep
    ST_READ  = 3'b010,                           // Read burst in progress
    ST_WRITE = 3'b100                            // Write burst in progress
  } psp_state_t;
endpackage : psp_pkg

// *** verilog/psp_fifo.sv ***
// Parameterised flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module psp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];               // Entries
  logic [PW-1:0]    wr_ptr;                      // Next slot to fill
  logic [PW-1:0]    rd_ptr;                      // Oldest entry
  logic [PW:0]      fill;                        // Entries held
  wire              push = in_valid_i & in_ready_o;
  wire              pop  = out_valid_o & out_ready_i;

  // Full and empty come straight from the count, so they never lie
  assign in_ready_o  = (fill != (PW+1)'(DEPTH));
  assign out_valid_o = (fill != '0);
  assign out_data_o  = store[rd_ptr];

  ////////////////////////////////////////////////////////////////////////////
  // Pointers and count
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)  rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      fill <= fill + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // Storage carries no reset; only the pointers say what is valid
  always_ff @(posedge clk_i) begin
    if (push) store[wr_ptr] <= in_data_i;
  end
endmodule : psp_fifo
`default_nettype wire

// *** verilog/psp_port.sv ***
// Pipelined burst static memory port: strobes, burst counter, writes, read pipe
//
// Notes on behaviour
// - Sync inputs on clock; enable, sleep, order async
// - Address captured only when fully selected and strobed
// - Master select inactive blocks processor strobe
// - Second select high-true, third low-true
// - Strobe loads address or deselects
// - No strobe: step when advance low, else hold
// - Global write writes every lane
// - Lane enables only under low qualifier
// - Any lane enable low means write
// - Byte write touches only enabled lanes
// - Drive bus only for enabled selected reads
// - Interleaved order: start XOR count
// - Linear order: start plus count, wrapping
// - Sleep deselects, contents kept
// - Asleep: ignore inputs, outputs released
// - Read data one edge after address
// - Advance ignored on processor strobe edge
// - Bus data latched on lane-enable edges
// - Controller strobe samples write controls immediately
`timescale 1ns/1ps
`default_nettype none
module psp_port (
  input  wire logic                       CLOCK_I,
  input  wire logic                       SYS_RST_I,
  input  wire logic [psp_pkg::ADDR_W-1:0] ADDR_I,
  input  wire logic                       MASTER_SELECT_N_I,
  input  wire logic                       SELECT_HI_I,
  input  wire logic                       SELECT_LO_N_I,
  input  wire logic                       PROC_ADDR_STROBE_N_I,
  input  wire logic                       CTRL_ADDR_STROBE_N_I,
  input  wire logic                       BURST_STEP_N_I,
  input  wire logic                       WRITE_ALL_N_I,
  input  wire logic                       BYTE_WRITE_QUAL_N_I,
  input  wire logic [psp_pkg::LANES-1:0]  LANE_WRITE_N_I,
  input  wire logic                       OUT_ENABLE_N_I,
  input  wire logic                       BURST_ORDER_SEL_N_I,
  input  wire logic                       SLEEP_REQUEST_I,
  input  wire logic [psp_pkg::DATA_W-1:0] DQ_I,
  output logic      [psp_pkg::DATA_W-1:0] DQ_O,
  output logic                            DQ_OE_O,
  output logic                            WBUF_READY_O
);
  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  psp_pkg::psp_state_t            state;          // Burst state
  psp_pkg::psp_state_t            next_state;     // Burst state after this edge
  logic [psp_pkg::ADDR_W-1:0]     addr_reg;       // Registered start address
  logic [psp_pkg::BURST_W-1:0]    cnt;            // Burst beat count
  logic                           rd_pend;        // Read address registered last edge
  logic                           out_valid;      // Output register holds read data
  logic [psp_pkg::DATA_W-1:0]     out_data;       // Output data register
  logic [psp_pkg::DATA_W-1:0]     mem [psp_pkg::MEM_DEPTH]; // Word store
  logic [psp_pkg::SYNC_STAGES-1:0] zz_sync;       // Sleep pin synchroniser
  logic [psp_pkg::SYNC_STAGES-1:0] lbo_sync;      // Order pin synchroniser
  logic                           sleep;          // Settled sleep level
  logic                           order_lin;      // Settled linear order choice

  ////////////////////////////////////////////////////////////////////////////
  // Asynchronous pins: three flops, a change counts when the last two agree
  // Both pins are static or slow, so four edges of lag cost nothing
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      zz_sync   <= psp_pkg::SYNC_LO;
      lbo_sync  <= psp_pkg::SYNC_HI;
      sleep     <= 1'b0;
      order_lin <= 1'b0;
    end else begin
      zz_sync  <= {zz_sync[1:0], SLEEP_REQUEST_I};
      lbo_sync <= {lbo_sync[1:0], BURST_ORDER_SEL_N_I};
      if (zz_sync[1] == zz_sync[2])   sleep     <= zz_sync[2];
      if (lbo_sync[1] == lbo_sync[2]) order_lin <= !lbo_sync[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strobe and select decode
  wire proc_req  = !PROC_ADDR_STROBE_N_I & !MASTER_SELECT_N_I;
  wire ctrl_req  = !CTRL_ADDR_STROBE_N_I;
  wire strobe    = proc_req | ctrl_req;
  // Selects only matter when a strobe samples them
  wire all_sel   = !MASTER_SELECT_N_I & SELECT_HI_I & !SELECT_LO_N_I;
  wire load      = !sleep & strobe & all_sel;
  wire deselect  = !sleep & strobe & !all_sel;
  wire in_burst  = (state != psp_pkg::ST_IDLE);
  // Continue needs no strobe taken (processor strobe counts only with master select low), so a taken strobe edge never steps
  wire cont      = !sleep & !strobe & in_burst;
  // The processor strobe wins; controller start only with it inactive
  wire ctrl_start = load & !proc_req;

  ////////////////////////////////////////////////////////////////////////////
  // Write decode
  wire lanes_low  = !(&LANE_WRITE_N_I);
  wire wr_req     = !WRITE_ALL_N_I | (!BYTE_WRITE_QUAL_N_I & lanes_low);
  wire [psp_pkg::LANES-1:0] lane_mask =
      !WRITE_ALL_N_I       ? psp_pkg::LANES_ALL :
      !BYTE_WRITE_QUAL_N_I ? ~LANE_WRITE_N_I :
                             psp_pkg::LANES_NONE;
  // A processor-started edge ignores the write controls and begins as a read
  wire start_wr   = ctrl_start & wr_req;
  wire cont_wr    = cont & wr_req;

  ////////////////////////////////////////////////////////////////////////////
  // Burst address
  wire [psp_pkg::BURST_W-1:0] start_low = addr_reg[psp_pkg::BURST_W-1:0];
  // Both orders wrap inside the aligned four-word block
  wire [psp_pkg::BURST_W-1:0] lin_low   = start_low + cnt;
  wire [psp_pkg::BURST_W-1:0] ilv_low   = start_low ^ cnt;
  wire [psp_pkg::BURST_W-1:0] burst_low = order_lin ? lin_low : ilv_low;
  // Upper bits never move during a burst
  wire [psp_pkg::ADDR_W-1:0]  cur_addr  =
      {addr_reg[psp_pkg::ADDR_W-1:psp_pkg::BURST_W], burst_low};
  // Advance is not looked at on a strobe edge
  wire step       = cont & !BURST_STEP_N_I;
  wire [psp_pkg::IDX_W-1:0] rd_idx = cur_addr[psp_pkg::IDX_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Write buffer between the bus and the store
  // A write edge while the buffer is full is dropped: watch the ready pin
  wire                        push_valid = start_wr | cont_wr;
  wire [psp_pkg::ADDR_W-1:0]  push_addr  = ctrl_start ? ADDR_I : cur_addr;
  wire [psp_pkg::FIFO_W-1:0]  push_word  = {push_addr, lane_mask, DQ_I};
  wire                        drain_valid;
  wire [psp_pkg::FIFO_W-1:0]  drain_word;
  // The store has one port; a pending read takes it and the buffer waits
  wire                        drain_ready = !rd_pend;
  wire [psp_pkg::DATA_W-1:0]  drain_data = drain_word[psp_pkg::DATA_W-1:0];
  wire [psp_pkg::LANES-1:0]   drain_mask =
      drain_word[psp_pkg::DATA_W +: psp_pkg::LANES];
  wire [psp_pkg::IDX_W-1:0]   drain_idx  =
      drain_word[psp_pkg::DATA_W + psp_pkg::LANES +: psp_pkg::IDX_W];

  psp_fifo #(
    .WIDTH (psp_pkg::FIFO_W),
    .DEPTH (psp_pkg::FIFO_DEPTH)
  ) u_wbuf (
    .clk_i       (CLOCK_I),
    .rst_i       (SYS_RST_I),
    .in_valid_i  (push_valid),
    .in_ready_o  (WBUF_READY_O),
    .in_data_i   (push_word),
    .out_valid_o (drain_valid),
    .out_ready_i (drain_ready),
    .out_data_o  (drain_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next burst state
  always_comb begin
    next_state = state;
    case (state)
      psp_pkg::ST_IDLE: begin
        if (load) next_state = start_wr ? psp_pkg::ST_WRITE : psp_pkg::ST_READ;
      end
      psp_pkg::ST_READ, psp_pkg::ST_WRITE: begin
        if (load)          next_state = start_wr ? psp_pkg::ST_WRITE : psp_pkg::ST_READ;
        else if (deselect) next_state = psp_pkg::ST_IDLE;
        else if (cont)     next_state = wr_req ? psp_pkg::ST_WRITE : psp_pkg::ST_READ;
      end
      default: next_state = psp_pkg::ST_IDLE;
    endcase
    // Sleep overrides every request and parks the burst
    if (sleep) next_state = psp_pkg::ST_IDLE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst control registers
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      state    <= psp_pkg::ST_IDLE;
      addr_reg <= '0;
      cnt      <= psp_pkg::CNT_ZERO;
    end else begin
      state <= next_state;
      if (load) begin
        addr_reg <= ADDR_I;
        cnt      <= psp_pkg::CNT_ZERO;
      end else if (step) begin
        cnt <= cnt + psp_pkg::CNT_ONE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read pipeline: address on one edge, output register on the next
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      rd_pend   <= 1'b0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      rd_pend   <= (load & !start_wr) | (cont & !wr_req);
      // Sleep also cancels a beat already in the pipe
      out_valid <= rd_pend & !sleep;
      if (rd_pend) out_data <= mem[rd_idx];
    end
  end

  // Store write, lane by lane; contents survive sleep and reset
  // A drain waits while a read owns the single store port
  always_ff @(posedge CLOCK_I) begin
    if (drain_valid & drain_ready) begin
      for (int l = 0; l < psp_pkg::LANES; l++) begin
        if (drain_mask[l])
          mem[drain_idx][l*psp_pkg::LANE_W +: psp_pkg::LANE_W] <=
              drain_data[l*psp_pkg::LANE_W +: psp_pkg::LANE_W];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive: output enable and sleep act without the clock
  assign DQ_O    = out_data;
  // The raw sleep pin releases the bus at once, before the synchroniser
  // A write edge clears the read pipe, so the bus is released one edge after it
  assign DQ_OE_O = out_valid & !OUT_ENABLE_N_I & !SLEEP_REQUEST_I;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_load_addr;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    load |=> (addr_reg == $past(ADDR_I)) && (cnt == psp_pkg::CNT_ZERO);
  endproperty
  a_load_addr: assert property (p_load_addr) else $error("address not loaded");

  property p_block;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    (!in_burst && MASTER_SELECT_N_I && CTRL_ADDR_STROBE_N_I) |=> !in_burst;
  endproperty
  a_block: assert property (p_block) else $error("blocked strobe started");

  property p_desel;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    (deselect && !SELECT_HI_I) |=> (state == psp_pkg::ST_IDLE) ##1 !out_valid;
  endproperty
  a_desel: assert property (p_desel) else $error("no deselect");

  property p_hold;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    (cont && BURST_STEP_N_I) |=> (cnt == $past(cnt));
  endproperty
  a_hold: assert property (p_hold) else $error("address moved on hold");

  property p_step;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    (cont && !BURST_STEP_N_I) |=> (cnt == $past(cnt) + psp_pkg::CNT_ONE);
  endproperty
  a_step: assert property (p_step) else $error("address did not step");

  property p_global;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    (push_valid && !WRITE_ALL_N_I) |-> (push_word[psp_pkg::DATA_W +: psp_pkg::LANES]
                                        == psp_pkg::LANES_ALL);
  endproperty
  a_global: assert property (p_global) else $error("global write partial");

  property p_readqual;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    (cont && WRITE_ALL_N_I && BYTE_WRITE_QUAL_N_I) |=> rd_pend ##1 out_valid;
  endproperty
  a_readqual: assert property (p_readqual) else $error("qualified read lost");

  property p_lanes;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    (cont_wr && WRITE_ALL_N_I) |-> (push_word[psp_pkg::DATA_W +: psp_pkg::LANES]
                                    == ~LANE_WRITE_N_I);
  endproperty
  a_lanes: assert property (p_lanes) else $error("wrong lane mask");

  property p_drive;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    DQ_OE_O |-> ($past(rd_pend) && !OUT_ENABLE_N_I && !$past(sleep));
  endproperty
  a_drive: assert property (p_drive) else $error("bus driven outside read");

  property p_sleep;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    sleep |=> (state == psp_pkg::ST_IDLE) && !out_valid && !DQ_OE_O;
  endproperty
  a_sleep: assert property (p_sleep) else $error("active while asleep");

  property p_upper;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    (cont && !load) |=> $stable(cur_addr[psp_pkg::ADDR_W-1:psp_pkg::BURST_W]);
  endproperty
  a_upper: assert property (p_upper) else $error("upper address moved");

  property p_procstart;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    (load && proc_req) |=> (state == psp_pkg::ST_READ) && (cnt == psp_pkg::CNT_ZERO);
  endproperty
  a_procstart: assert property (p_procstart) else $error("advance honoured at start");

  // Burst order, write start and read pipe
  property p_linear;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    (order_lin && step) |=> (burst_low == $past(burst_low) + psp_pkg::CNT_ONE);
  endproperty
  a_linear: assert property (p_linear) else $error("linear step wrong");

  property p_ilv;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    (!order_lin && step && (cnt == psp_pkg::CNT_ZERO))
      |=> (burst_low == ($past(start_low) ^ psp_pkg::CNT_ONE));
  endproperty
  a_ilv: assert property (p_ilv) else $error("interleaved step wrong");

  property p_ctrl_wr;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    start_wr |=> (state == psp_pkg::ST_WRITE) ##1 !DQ_OE_O;
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("write start lost");

  property p_proc_rd;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    (load && proc_req) |-> !push_valid ##1 rd_pend;
  endproperty
  a_proc_rd: assert property (p_proc_rd) else $error("processor start wrote");

  property p_lane_data;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    cont_wr |-> push_valid && (push_word[psp_pkg::DATA_W-1:0] == DQ_I);
  endproperty
  a_lane_data: assert property (p_lane_data) else $error("bus data not latched");

  property p_pipe;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
    (rd_pend && !sleep) |=> out_valid;
  endproperty
  a_pipe: assert property (p_pipe) else $error("read beat missing");

  c_read_burst: cover property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    load ##1 step [*3] ##1 out_valid);
  c_ctrl_write: cover property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    start_wr ##1 cont_wr ##1 cont_wr);
  c_sleep: cover property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    out_valid ##1 sleep ##1 !sleep);
  c_full: cover property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    !WBUF_READY_O);
endmodule : psp_port
`default_nettype wire

// *** tb/psp_master.sv ***
// Bus master model for the memory port: strobes, selects, write controls and data
`timescale 1ns/1ps
`default_nettype none
module psp_master (
  input  wire logic                       clk_i,
  output logic      [psp_pkg::ADDR_W-1:0] addr_o,
  output logic                            msel_n_o,
  output logic                            sel_hi_o,
  output logic                            sel_lo_n_o,
  output logic                            proc_n_o,
  output logic                            ctrl_n_o,
  output logic                            step_n_o,
  output logic                            wall_n_o,
  output logic                            qual_n_o,
  output logic      [psp_pkg::LANES-1:0]  lane_n_o,
  output logic                            oe_n_o,
  output logic      [psp_pkg::DATA_W-1:0] dq_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Start idle: no strobe, no write, selects active
  initial begin
    {ctrl_n_o, proc_n_o, msel_n_o, sel_hi_o, sel_lo_n_o, step_n_o} = 6'h35;
    {wall_n_o, qual_n_o, lane_n_o, oe_n_o} = 7'h7e;
    addr_o = '0;
    dq_o = '0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One bus cycle, launched at the falling edge and held a full period
  task automatic cyc(input logic c, p, m, input logic [1:0] s, input logic burst_step_n, wa, q,
                     input logic [3:0] ln, input logic [psp_pkg::ADDR_W-1:0] a,
                     input logic [psp_pkg::DATA_W-1:0] d);
    @(negedge clk_i);
    {ctrl_n_o, proc_n_o, msel_n_o, sel_hi_o, sel_lo_n_o, step_n_o} = {c, p, m, s, burst_step_n};
    {wall_n_o, qual_n_o, lane_n_o, addr_o} = {wa, q, ln, a};
    // Released lines toggle, so stale data never passes for fresh data
    dq_o = (!wa || (!q && ln != 4'hf)) ? d : ~dq_o;
  endtask : cyc
  // No strobe, advance random
  task automatic idle(input int n);
    repeat (n) cyc(1, 1, 0, 2'b10, 1'($urandom), 1, 1, 4'($urandom), 20'($urandom), dq_o);
  endtask : idle
  // Controller strobe with the second select off ends any burst
  task automatic desel;
    cyc(0, 1, 0, 2'b00, 1, 1, 1, 4'hf, addr_o, dq_o);
  endtask : desel
  // Single controller-started cycle; output enable only when it is a read
  task automatic wr(input logic [psp_pkg::ADDR_W-1:0] a, input logic wa, q,
                    input logic [3:0] ln, input logic [psp_pkg::DATA_W-1:0] d);
    oe_n_o = !(wa && (q || ln == 4'hf));
    cyc(0, 1, 0, 2'b10, 1, wa, q, ln, a, d);
    desel();
    idle(1);
  endtask : wr
  // Load plus five continue cycles, advance per bit of advs
  task automatic rd(input logic [psp_pkg::ADDR_W-1:0] a, input logic p,
                    input logic [7:0] advs, input logic oe);
    oe_n_o = oe;
    cyc(p, !p, 0, 2'b10, 0, 1, 1, 4'hf, a, dq_o);
    for (int i = 0; i < 5; i++) cyc(1, 1, 0, 2'b10, advs[i], 1, 1, 4'hf, a, dq_o);
    desel();
    idle(1);
  endtask : rd
endmodule : psp_master
`default_nettype wire

// *** tb/test_pipelined_burst_sram_port.sv ***
// Self-checking bench for the pipelined burst memory port and its write buffer
`timescale 1ns/1ps
`default_nettype none
module test_pipelined_burst_sram_port;
  logic                         clock   = 1'b0;  // 100 MHz
  logic                         sys_rst = 1'b1;  // Async reset, high
  logic                         order_n = 1'b1;  // High: interleaved
  logic                         sleep   = 1'b0;  // Sleep pin
  wire  logic [19:0]            addr;
  wire  logic                   msel_n, sel_hi, sel_lo_n, proc_n, ctrl_n, step_n;
  wire  logic                   wall_n, qual_n, oe_n, dq_oe, wbuf_rdy;
  wire  logic [3:0]             lane_n;
  wire  logic [31:0]            dq_m, dq_o;
  logic       [31:0]            mem [16];        // Expected store contents
  logic       [31:0]            exp_q [$];       // Expected read beats, oldest first
  int                           n_mismatch = 0;
  int                           samples_checked = 0;
  int                           cycles = 0;
  always #5 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////
  psp_master m (.clk_i(clock), .addr_o(addr), .msel_n_o(msel_n), .sel_hi_o(sel_hi),
    .sel_lo_n_o(sel_lo_n), .proc_n_o(proc_n), .ctrl_n_o(ctrl_n), .step_n_o(step_n),
    .wall_n_o(wall_n), .qual_n_o(qual_n), .lane_n_o(lane_n), .oe_n_o(oe_n), .dq_o(dq_m));
  psp_port dut (.CLOCK_I(clock), .SYS_RST_I(sys_rst), .ADDR_I(addr),
    .MASTER_SELECT_N_I(msel_n), .SELECT_HI_I(sel_hi), .SELECT_LO_N_I(sel_lo_n),
    .PROC_ADDR_STROBE_N_I(proc_n), .CTRL_ADDR_STROBE_N_I(ctrl_n), .BURST_STEP_N_I(step_n),
    .WRITE_ALL_N_I(wall_n), .BYTE_WRITE_QUAL_N_I(qual_n), .LANE_WRITE_N_I(lane_n),
    .OUT_ENABLE_N_I(oe_n), .BURST_ORDER_SEL_N_I(order_n), .SLEEP_REQUEST_I(sleep),
    .DQ_I(dq_m), .DQ_O(dq_o), .DQ_OE_O(dq_oe), .WBUF_READY_O(wbuf_rdy));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  // Burst address of beat k: linear adds, interleaved XORs
  function automatic logic [1:0] bseq(input logic [1:0] st, k, input logic lin);
    return lin ? st + k : st ^ k;
  endfunction : bseq
  ////////////////////////////////////////////////////////////////////////////
  // Watch the bus after each edge; any drive must match the oldest expected beat
  always @(posedge clock) begin
    #2;
    if (dq_oe === 1'b1 && exp_q.size() == 0) check({31'h0, dq_oe}, 32'h0);
    else if (dq_oe === 1'b1) check(dq_o, exp_q.pop_front());
  end
  // Hang guard, well above the roughly 530 cycles the run needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      $display("ERROR at %0t: timeout", $time);
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [19:0] a;
    logic [31:0] d;
    logic [3:0]  ln;
    logic [7:0]  advs;
    logic        q;
    logic [1:0]  k;
    void'($urandom(95));
    repeat (10) @(negedge clock);
    sys_rst = 1'b0;
    m.idle(4);
    check({31'h0, dq_oe}, 32'h0);
    check({31'h0, wbuf_rdy}, 32'h1);
    // Global writes fill every word, lane enables random
    for (int i = 0; i < 16; i++) begin
      a = 20'($urandom);
      a[3:0] = 4'(i);
      mem[i] = $urandom;
      m.wr(a, 1'b0, 1'(i), 4'($urandom), mem[i]);
      m.idle(2);
    end
    $display("done: global writes");
    // Byte writes, or reads when the qualifier or all lane enables are high
    for (int i = 0; i < 12; i++) begin
      a = 20'($urandom);
      {q, ln, d} = {1'($urandom), 4'($urandom), $urandom};
      if (q || ln == 4'hf) exp_q.push_back(mem[a[3:0]]);
      else for (int l = 0; l < 4; l++) if (!ln[l]) mem[a[3:0]][8*l +: 8] = d[8*l +: 8];
      m.wr(a, 1'b1, q, ln, d);
      m.idle(4);
    end
    $display("done: byte writes");
    // Bursts in both orders, random starts, advance and suspend mixed
    for (int o = 0; o < 2; o++) begin
      order_n = o[0];
      m.idle(4);
      for (int s = 0; s < 8; s++) begin
        a = 20'($urandom);
        advs = 8'($urandom);
        k = 2'h0;
        exp_q.push_back(mem[a[3:0]]);
        for (int j = 0; j < 5; j++) begin
          k = k + 2'(!advs[j]);
          exp_q.push_back(mem[{a[3:2], bseq(a[1:0], k, !order_n)}]);
        end
        m.rd(a, s[0], advs, 1'b0);
      end
    end
    $display("done: bursts");
    // Writes that must not be taken
    m.oe_n_o = 1'b1;
    m.cyc(1, 0, 1, 2'b10, 1, 0, 0, 4'h0, 20'h0, 32'h0);
    m.cyc(0, 1, 1, 2'b10, 1, 0, 0, 4'h0, 20'h1, 32'h0);
    m.cyc(0, 1, 0, 2'b11, 1, 0, 0, 4'h0, 20'h2, 32'h0);
    m.cyc(0, 1, 0, 2'b00, 1, 0, 0, 4'h0, 20'h3, 32'h0);
    m.cyc(1, 0, 0, 2'b10, 1, 0, 0, 4'h0, 20'h4, 32'h0);
    m.idle(4);
    m.rd(20'h5, 1'b0, 8'h00, 1'b1);
    $display("done: refused cycles");
    // Sleep: accesses ignored, contents kept
    m.idle(4);
    sleep = 1'b1;
    m.idle(4);
    check({31'h0, dq_oe}, 32'h0);
    m.wr(20'h7, 1'b0, 1'b0, 4'h0, ~mem[7]);
    m.rd(20'h7, 1'b0, 8'h00, 1'b0);
    sleep = 1'b0;
    m.idle(6);
    for (int i = 0; i < 16; i++) begin
      repeat (6) exp_q.push_back(mem[i]);
      m.rd(20'(i), 1'b0, 8'hff, 1'b0);
    end
    m.idle(2);
    check(32'(exp_q.size()), 32'h0);
    $display("done: sleep and readback");
    // Write burst through the buffer: a write at the start, then the address
    // before each step takes lane writes; read the block back afterwards
    m.oe_n_o = 1'b1;
    a = 20'($urandom);
    mem[a[3:0]] = $urandom;
    m.cyc(0, 1, 0, 2'b10, 1, 0, 1, 4'hf, a, mem[a[3:0]]);
    for (int j = 0; j < 3; j++) begin
      {ln, d} = {4'($urandom), $urandom};
      k = bseq(a[1:0], 2'(j), !order_n);
      for (int l = 0; l < 4; l++) if (!ln[l]) mem[{a[3:2], k}][8*l +: 8] = d[8*l +: 8];
      m.cyc(1, 1, 0, 2'b10, 0, 1, 0, ln, a, d);
      check({31'h0, wbuf_rdy}, 32'h1);
    end
    m.desel();
    m.idle(4);
    check({31'h0, dq_oe}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      repeat (6) exp_q.push_back(mem[{a[3:2], 2'(i)}]);
      m.rd({a[19:2], 2'(i)}, 1'b0, 8'hff, 1'b0);
    end
    m.idle(2);
    check(32'(exp_q.size()), 32'h0);
    $display("done: write burst");
    conclude();
  end
endmodule : test_pipelined_burst_sram_port
`default_nettype wire
